// ### odac_pkg.sv
// Package of constants and types shared by both ends of the octal converter serial link.
package odac_pkg;
   localparam int          ODAC_NCH        = 8;
   localparam logic [6:0]  ODAC_BCAST_ADDR = 7'h47;
   localparam logic [6:0]  ODAC_BASE_ADDR  = 7'h48;
   localparam logic [3:0]  ODAC_CMD_WR     = 4'h0;
   localparam logic [3:0]  ODAC_CMD_UPD    = 4'h1;
   localparam logic [3:0]  ODAC_CMD_WR_ALL = 4'h2;
   localparam logic [3:0]  ODAC_CMD_WR_UPD = 4'h3;
   localparam logic [3:0]  ODAC_CH_ALL     = 4'hf;
   localparam int          ODAC_CMD_HI     = 7;
   localparam int          ODAC_CMD_LO     = 4;
   localparam int          ODAC_CH_HI      = 3;
   localparam int          ODAC_CH_LO      = 0;
   localparam int          ODAC_CODE_BITS  = 12;
   localparam logic [2:0]  ODAC_BIT_LAST   = 3'h0;
   localparam logic [2:0]  ODAC_BIT_FIRST  = 3'h7;
   localparam logic [15:0] ODAC_WORD_RST   = 16'h0000;
   localparam logic [3:0]  ODAC_CLK_DIV    = 4'h8;
   localparam logic [3:0]  ODAC_CLK_HALF   = 4'h4;
   typedef enum logic [1:0] {ODAC_OP_WRITE, ODAC_OP_READ, ODAC_OP_READ_LAST} odac_op_t;
endpackage : odac_pkg

// ### odac_if.sv
// Interface joining the two ends over a clock and a shared data wire.
interface odac_if;
   logic scl;
   logic sda_ctl_o;
   logic sda_ctl_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic sda;
   assign sda = !((sda_ctl_oe && !sda_ctl_o) || (sda_dev_oe && !sda_dev_o));
   modport ctl (output scl, output sda_ctl_o, output sda_ctl_oe, input sda);
   modport dev (input scl, output sda_dev_o, output sda_dev_oe, input sda);
endinterface : odac_if

// ### odac_target.sv
// Target end: serial link decode, channel registers and readback, on the link clock.
//
// Functional notes
// - Upper then lower data byte to selected register.
// - Apply value at ack falling edge after lower.
// - Answer broadcast address whatever strapped address.
// - Broadcast address for writes only, never read.
// - Broadcast byte is 1000111 then write bit.
// - Read starts with address, write bit, acknowledged.
// - Command byte naming register is then acknowledged.
// - Repeated start with read address acknowledged.
// - Device drives upper byte, controller acknowledges.
// - Device drives lower byte, controller final ack; the controller here leaves that bit high (no acknowledge).
// - Bare read returns last written register.
// - Codes left-justified from top data bit.
// - Command nibble high, channel nibble low.
module odac_target
   import odac_pkg::*;
(
   // Clock and reset
   input  wire logic                       i_ref_clk,
   input  wire logic                       i_rstn,
   // Link
   odac_if.dev                             link,
   // Strap
   input  wire logic [2:0]                 i_addr_strap,
   // Converter side, reference domain
   output logic [ODAC_NCH*ODAC_CODE_BITS-1:0] o_dac_code,
   output logic                            o_update
);
   typedef enum logic [3:0] {ODAC_S_IDLE, ODAC_S_ADDR, ODAC_S_CMD, ODAC_S_HI, ODAC_S_LO,
                             ODAC_S_RD_HI, ODAC_S_RD_LO, ODAC_S_SKIP,
                             ODAC_S_RD_ACK} odac_state_t;
   // Link-domain state.
   logic                       sda_q_r, sda_q_nxt;
   logic                       scl_lv;
   odac_state_t                st_r, st_nxt;
   logic [2:0]                 bit_r, bit_nxt;
   logic [7:0]                 sh_r, sh_nxt;
   logic [7:0]                 rx_byte;
   logic                       ack_r, ack_nxt;
   logic                       drv_r, drv_nxt;
   logic [7:0]                 ca_r, ca_nxt;
   logic [7:0]                 hi_r, hi_nxt;
   logic [15:0]                word_r, word_nxt;
   logic [7:0]                 last_ca_r, last_ca_nxt;
   logic [15:0]                tx_r, tx_nxt;
   logic                       cmd_seen_r, cmd_seen_nxt;
   logic                       tgl_r, tgl_nxt;
   logic                       start_r, start_nxt;
   logic                       stop_r, stop_nxt;
   logic [ODAC_NCH*16-1:0]     inreg_r, inreg_nxt;
   logic [ODAC_NCH*16-1:0]     outreg_r, outreg_nxt;
   logic [6:0]                 own_addr;
   logic [7:0]                 rd_sel;
   logic [15:0]                rd_word;
   // Reference-domain state.
   logic [2:0]                 sync_r, sync_nxt;
   logic [ODAC_NCH*ODAC_CODE_BITS-1:0] code_r, code_nxt;
   logic                       upd_r, upd_nxt;

   assign own_addr = {ODAC_BASE_ADDR[6:3], i_addr_strap};
   assign scl_lv   = link.scl;

   // Start and stop are data edges while the clock is high; the clock level is sampled on
   // both edges of the data wire, so these flops need neither the link clock nor the reference clock.
   always_ff @(negedge link.sda or negedge i_rstn) begin
      if (!i_rstn) begin
         start_r <= 1'b0;
      end else begin
         start_r <= start_nxt;
      end
   end
   always_ff @(posedge link.sda or negedge i_rstn) begin
      if (!i_rstn) begin
         stop_r <= 1'b0;
      end else begin
         stop_r <= stop_nxt;
      end
   end
   always_comb begin
      start_nxt = scl_lv ? !start_r : start_r;
      stop_nxt  = scl_lv ? !stop_r : stop_r;
   end

   // Readback selection: a command-selected register or the last written one.
   always_comb begin
      rd_sel  = cmd_seen_r ? ca_r : last_ca_r;
      rd_word = ODAC_WORD_RST;
      for (int k = 0; k < ODAC_NCH; k++) begin
         if (rd_sel[ODAC_CH_HI:ODAC_CH_LO] == k[3:0]) begin
            rd_word = (rd_sel[ODAC_CMD_HI:ODAC_CMD_LO] == ODAC_CMD_UPD)
                      ? outreg_r[k*16 +: 16] : inreg_r[k*16 +: 16];
         end
      end
   end

   logic start_seen_r, stop_seen_r, start_seen_nxt, stop_seen_nxt;
   // The last bit of a byte is still in the rising-edge sample at the falling edge.
   assign rx_byte = {sh_r[6:0], sda_q_r};
   always_comb begin
      st_nxt = st_r; bit_nxt = bit_r; sh_nxt = sh_r; ack_nxt = 1'b0; drv_nxt = drv_r;
      ca_nxt = ca_r; hi_nxt = hi_r; word_nxt = word_r; last_ca_nxt = last_ca_r;
      tx_nxt = tx_r; cmd_seen_nxt = cmd_seen_r; tgl_nxt = tgl_r;
      inreg_nxt = inreg_r; outreg_nxt = outreg_r;
      start_seen_nxt = start_r; stop_seen_nxt = stop_r;
      if (start_r != start_seen_r) begin
         st_nxt  = ODAC_S_ADDR;
         bit_nxt = ODAC_BIT_FIRST;
         drv_nxt = 1'b0;
         // A stop since the last start ends any command kept for a repeated start.
         if (stop_r != stop_seen_r) begin
            cmd_seen_nxt = 1'b0;
         end
      end else if (stop_r != stop_seen_r) begin
         st_nxt  = ODAC_S_IDLE;
         drv_nxt = 1'b0;
      end else if (ack_r) begin
         // Falling edge closing an acknowledge given by this end.
         if (st_r == ODAC_S_RD_HI) begin
            drv_nxt = 1'b1;
         end
         if (st_r == ODAC_S_SKIP) begin
            st_nxt = ODAC_S_IDLE;
            if (ca_r[ODAC_CMD_HI:ODAC_CMD_LO] <= ODAC_CMD_WR_UPD) begin
               last_ca_nxt = ca_r;
               for (int k = 0; k < ODAC_NCH; k++) begin
                  if (ca_r[ODAC_CH_HI:ODAC_CH_LO] == k[3:0]
                      || ca_r[ODAC_CH_HI:ODAC_CH_LO] == ODAC_CH_ALL) begin
                     if (ca_r[ODAC_CMD_HI:ODAC_CMD_LO] != ODAC_CMD_UPD) begin
                        inreg_nxt[k*16 +: 16] = word_r;
                     end
                     if (ca_r[ODAC_CMD_HI:ODAC_CMD_LO] == ODAC_CMD_UPD) begin
                        outreg_nxt[k*16 +: 16] = inreg_r[k*16 +: 16];
                     end else if (ca_r[ODAC_CMD_HI:ODAC_CMD_LO] == ODAC_CMD_WR_UPD) begin
                        outreg_nxt[k*16 +: 16] = word_r;
                     end
                  end
                  if (ca_r[ODAC_CMD_HI:ODAC_CMD_LO] == ODAC_CMD_WR_ALL) begin
                     outreg_nxt[k*16 +: 16] = inreg_nxt[k*16 +: 16];
                  end
               end
               tgl_nxt = !tgl_r;
            end
         end
      end else if (st_r == ODAC_S_RD_ACK) begin
         // Only an acknowledged upper byte is followed by the lower one.
         st_nxt  = sda_q_r ? ODAC_S_IDLE : ODAC_S_RD_LO;
         drv_nxt = !sda_q_r;
      end else if (st_r != ODAC_S_IDLE && st_r != ODAC_S_SKIP) begin
         sh_nxt = rx_byte;
         if (bit_r != ODAC_BIT_LAST) begin
            bit_nxt = bit_r - 3'h1;
         end else begin
            bit_nxt = ODAC_BIT_FIRST;
            case (st_r)
               ODAC_S_ADDR: begin
                  if (rx_byte[7:1] == own_addr) begin
                     ack_nxt = 1'b1;
                     st_nxt  = rx_byte[0] ? ODAC_S_RD_HI : ODAC_S_CMD;
                     tx_nxt  = rd_word;
                  end else if (rx_byte == {ODAC_BCAST_ADDR, 1'b0}) begin
                     // A broadcast read falls through and is left unanswered.
                     ack_nxt = 1'b1;
                     st_nxt  = ODAC_S_CMD;
                  end else begin
                     st_nxt = ODAC_S_IDLE;
                  end
               end
               ODAC_S_CMD: begin
                  ack_nxt      = 1'b1;
                  ca_nxt       = rx_byte;
                  cmd_seen_nxt = 1'b1;
                  st_nxt       = ODAC_S_HI;
               end
               ODAC_S_HI: begin
                  ack_nxt = 1'b1;
                  hi_nxt  = rx_byte;
                  st_nxt  = ODAC_S_LO;
               end
               ODAC_S_LO: begin
                  ack_nxt  = 1'b1;
                  word_nxt = {hi_r, rx_byte};
                  st_nxt   = ODAC_S_SKIP;
               end
               ODAC_S_RD_HI: begin
                  drv_nxt = 1'b0;
                  st_nxt  = ODAC_S_RD_ACK;
               end
               default: begin
                  drv_nxt = 1'b0;
                  st_nxt  = ODAC_S_IDLE;
               end
            endcase
         end
      end
   end

   // Bits are taken on the rising clock edge; drive changes on the falling edge.
   always_ff @(negedge link.scl or negedge i_rstn) begin
      if (!i_rstn) begin
         st_r <= ODAC_S_IDLE; bit_r <= ODAC_BIT_FIRST; sh_r <= 8'h00; ack_r <= 1'b0;
         drv_r <= 1'b0; ca_r <= 8'h00; hi_r <= 8'h00; word_r <= ODAC_WORD_RST;
         last_ca_r <= 8'h00; tx_r <= ODAC_WORD_RST; cmd_seen_r <= 1'b0; tgl_r <= 1'b0;
         inreg_r <= '0; outreg_r <= '0; start_seen_r <= 1'b0; stop_seen_r <= 1'b0;
      end else begin
         st_r <= st_nxt; bit_r <= bit_nxt; sh_r <= sh_nxt; ack_r <= ack_nxt;
         drv_r <= drv_nxt; ca_r <= ca_nxt; hi_r <= hi_nxt; word_r <= word_nxt;
         last_ca_r <= last_ca_nxt; tx_r <= tx_nxt; cmd_seen_r <= cmd_seen_nxt; tgl_r <= tgl_nxt;
         inreg_r <= inreg_nxt; outreg_r <= outreg_nxt;
         start_seen_r <= start_seen_nxt; stop_seen_r <= stop_seen_nxt;
      end
   end
   // Data is sampled on the rising edge, away from the falling edge where both ends move it.
   assign sda_q_nxt = link.sda;
   always_ff @(posedge link.scl or negedge i_rstn) begin
      if (!i_rstn) begin
         sda_q_r <= 1'b1;
      end else begin
         sda_q_r <= sda_q_nxt;
      end
   end

   // Open-drain data: pull low for acknowledge or for a zero data bit.
   assign link.sda_dev_o  = 1'b0;
   assign link.sda_dev_oe = ack_r || (drv_r && !tx_r[{(st_r == ODAC_S_RD_HI), bit_r}]);

   // Update event crosses to the reference clock as a toggle.
   always_comb begin
      sync_nxt = {sync_r[1:0], tgl_r};
      upd_nxt  = sync_r[2] ^ sync_r[1];
      code_nxt = code_r;
      for (int k = 0; k < ODAC_NCH; k++) begin
         if (upd_nxt) begin
            code_nxt[k*ODAC_CODE_BITS +: ODAC_CODE_BITS] = outreg_r[k*16+15 -: ODAC_CODE_BITS];
         end
      end
   end
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sync_r <= 3'h0; code_r <= '0; upd_r <= 1'b0;
      end else begin
         sync_r <= sync_nxt; code_r <= code_nxt; upd_r <= upd_nxt;
      end
   end
   assign o_dac_code = code_r;
   assign o_update   = upd_r;
endmodule : odac_target

// ### odac_ctl.sv
// Controller end: divides its clock to make the link clock and runs write and read frames.
module odac_ctl
   import odac_pkg::*;
(
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rstn,
   // Link
   odac_if.ctl              link,
   // Request
   input  wire logic        i_req,
   input  wire odac_op_t    i_op,
   input  wire logic [6:0]  i_addr,
   input  wire logic [7:0]  i_ca,
   input  wire logic [15:0] i_wdata,
   // Answer
   output logic             o_busy,
   output logic             o_done,
   output logic             o_nack,
   output logic [15:0]      o_rdata
);
   typedef enum logic [2:0] {ODAC_C_IDLE, ODAC_C_START, ODAC_C_BYTE, ODAC_C_RSTART,
                             ODAC_C_STOP} odac_cst_t;
   odac_cst_t   st_r, st_nxt;
   logic [3:0]  div_r, div_nxt;
   logic        scl_r, scl_nxt, sdo_r, sdo_nxt;
   logic [3:0]  bit_r, bit_nxt;
   logic [2:0]  idx_r, idx_nxt;
   logic [7:0]  sh_r, sh_nxt;
   logic [15:0] rd_r, rd_nxt;
   logic [2:0]  s1_r, s1_nxt;
   logic        busy_r, busy_nxt, done_r, done_nxt, nack_r, nack_nxt;
   odac_op_t    op_r, op_nxt;
   logic [6:0]  ad_r, ad_nxt;
   logic [7:0]  ca_r, ca_nxt;
   logic [15:0] wd_r, wd_nxt;
   logic        sda_s0_r, sda_s1_r;
   logic        tick_lo, tick_hi, rd_byte;

   // Link data passes two flops before use.
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sda_s0_r <= 1'b1; sda_s1_r <= 1'b1;
      end else begin
         sda_s0_r <= link.sda; sda_s1_r <= sda_s0_r;
      end
   end

   assign tick_lo = (div_r == ODAC_CLK_HALF - 4'h1);
   assign tick_hi = (div_r == ODAC_CLK_DIV - 4'h1);
   // Byte sequence index: address, command, data, data (or read address, read bytes).
   assign rd_byte = (op_r == ODAC_OP_READ_LAST) ? (idx_r >= 3'h1) : (op_r == ODAC_OP_READ && idx_r >= 3'h3);

   always_comb begin
      st_nxt = st_r; div_nxt = div_r + 4'h1; scl_nxt = scl_r; sdo_nxt = sdo_r;
      bit_nxt = bit_r; idx_nxt = idx_r; sh_nxt = sh_r; rd_nxt = rd_r; s1_nxt = s1_r;
      busy_nxt = busy_r; done_nxt = 1'b0; nack_nxt = nack_r;
      op_nxt = op_r; ad_nxt = ad_r; ca_nxt = ca_r; wd_nxt = wd_r;
      if (tick_hi) begin
         div_nxt = 4'h0;
      end
      case (st_r)
         ODAC_C_IDLE: begin
            div_nxt = 4'h0; scl_nxt = 1'b1; sdo_nxt = 1'b1;
            if (i_req) begin
               op_nxt = i_op; ad_nxt = i_addr; ca_nxt = i_ca; wd_nxt = i_wdata;
               busy_nxt = 1'b1; nack_nxt = 1'b0; idx_nxt = 3'h0; st_nxt = ODAC_C_START;
            end
         end
         ODAC_C_RSTART: begin
            // Release data while the clock is low, then raise the clock for a fresh start.
            if (tick_lo) begin
               scl_nxt = 1'b0;
            end
            if (div_r == ODAC_CLK_HALF) begin
               sdo_nxt = 1'b1;
            end
            if (tick_hi) begin
               scl_nxt = 1'b1;
               st_nxt  = ODAC_C_START;
            end
         end
         ODAC_C_START: begin
            if (tick_lo) begin
               sdo_nxt = 1'b0;
            end
            if (tick_hi) begin
               scl_nxt = 1'b0; bit_nxt = 4'h0; st_nxt = ODAC_C_BYTE;
               sh_nxt = (idx_r == 3'h0 && op_r == ODAC_OP_WRITE) ? {ad_r, 1'b0}
                      : (op_r == ODAC_OP_READ_LAST || idx_r != 3'h0) ? {ad_r, 1'b1}
                      : {ad_r, 1'b0};
            end
         end
         ODAC_C_BYTE: begin
            if (tick_lo) begin
               scl_nxt = 1'b0;
            end
            // Data moves a cycle after the clock falls, so no data edge can pass for a start.
            if (div_r == ODAC_CLK_HALF) begin
               sdo_nxt = (bit_r == 4'h8) ? !(rd_byte && idx_r != s1_r) : (rd_byte ? 1'b1 : sh_r[7]);
            end
            if (tick_hi) begin
               scl_nxt = 1'b1;
            end
            if (tick_lo && bit_r != 4'h0) begin
            end
            if (div_r == ODAC_CLK_HALF - 4'h2 && scl_r) begin
               if (bit_r == 4'h8) begin
                  if (!rd_byte && sda_s1_r) begin
                     nack_nxt = 1'b1; st_nxt = ODAC_C_STOP;
                  end else begin
                     idx_nxt = idx_r + 3'h1; bit_nxt = 4'h0;
                     sh_nxt = (idx_r == 3'h0) ? ca_r : (idx_r == 3'h1) ? wd_r[15:8] : wd_r[7:0];
                     if ((op_r == ODAC_OP_WRITE && idx_r == 3'h3) || idx_r == s1_r) begin
                        st_nxt = ODAC_C_STOP;
                     end else if (op_r == ODAC_OP_READ && idx_r == 3'h1) begin
                        st_nxt = ODAC_C_RSTART;
                     end
                  end
               end else begin
                  if (rd_byte) begin
                     rd_nxt = {rd_r[14:0], sda_s1_r};
                  end
                  sh_nxt = {sh_r[6:0], 1'b0}; bit_nxt = bit_r + 4'h1;
               end
            end
         end
         ODAC_C_STOP: begin
            if (tick_lo) begin
               scl_nxt = 1'b0;
            end
            if (div_r == ODAC_CLK_HALF) begin
               sdo_nxt = 1'b0;
            end
            if (tick_hi) begin
               scl_nxt = 1'b1;
            end
            if (div_r == ODAC_CLK_HALF - 4'h2 && scl_r) begin
               sdo_nxt = 1'b1; busy_nxt = 1'b0; done_nxt = 1'b1; st_nxt = ODAC_C_IDLE;
            end
         end
         default: begin
            st_nxt = ODAC_C_IDLE;
         end
      endcase
      s1_nxt = (op_nxt == ODAC_OP_READ) ? 3'h4 : (op_nxt == ODAC_OP_READ_LAST) ? 3'h2 : 3'h7;
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_r <= ODAC_C_IDLE; div_r <= 4'h0; scl_r <= 1'b1; sdo_r <= 1'b1; bit_r <= 4'h0;
         idx_r <= 3'h0; sh_r <= 8'h00; rd_r <= 16'h0000; s1_r <= 3'h7; busy_r <= 1'b0;
         done_r <= 1'b0; nack_r <= 1'b0; op_r <= ODAC_OP_WRITE; ad_r <= 7'h00;
         ca_r <= 8'h00; wd_r <= 16'h0000;
      end else begin
         st_r <= st_nxt; div_r <= div_nxt; scl_r <= scl_nxt; sdo_r <= sdo_nxt; bit_r <= bit_nxt;
         idx_r <= idx_nxt; sh_r <= sh_nxt; rd_r <= rd_nxt; s1_r <= s1_nxt; busy_r <= busy_nxt;
         done_r <= done_nxt; nack_r <= nack_nxt; op_r <= op_nxt; ad_r <= ad_nxt;
         ca_r <= ca_nxt; wd_r <= wd_nxt;
      end
   end
   assign link.scl        = scl_r;
   assign link.sda_ctl_o  = 1'b0;
   assign link.sda_ctl_oe = !sdo_r;
   assign o_busy  = busy_r;
   assign o_done  = done_r;
   assign o_nack  = nack_r;
   assign o_rdata = rd_r;
endmodule : odac_ctl

// ### odac_link_checker.sv
// Checker of wire timing on the serial link between the two ends.
module odac_link_checker (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   // Link wires
   input wire logic scl,
   input wire logic sda_ctl_o,
   input wire logic sda_ctl_oe,
   input wire logic sda_dev_o,
   input wire logic sda_dev_oe,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   // Each link clock phase lasts at least half of the divided period.
   sequence s_hi;
      scl [*4];
   endsequence
   sequence s_lo;
      !scl [*4];
   endsequence
   chk_idle_release: assert property ($rose(i_rstn) |-> scl && sda)
      else $error("link not idle after reset");
   chk_scl_high_len: assert property ($rose(scl) |-> s_hi)
      else $error("link clock high phase too short");
   chk_scl_low_len: assert property ($fell(scl) |-> s_lo)
      else $error("link clock low phase too short");
   chk_start_clocks: assert property ($fell(sda) && scl |-> ##[1:16] !scl)
      else $error("no clock after start");
   chk_stop_idle: assert property ($rose(sda) && scl |-> s_hi)
      else $error("clock moved right after stop");
   // The target may only move the data wire while the clock is low.
   chk_dev_oe_steady: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
      else $error("target moved data during clock high");
   chk_dev_drive_low: assert property ($rose(sda_dev_oe) |-> !scl)
      else $error("target began driving during clock high");
   chk_dev_drive_bound: assert property (sda_dev_oe |-> ##[1:80] !sda_dev_oe)
      else $error("target held data wire too long");
   cover property ($rose(sda_dev_oe));
endmodule // odac_link_checker

// ### tb.sv
// Testbench driving the controller end against the target end.
module tb;
   import odac_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic             i_ref_clk;
   logic             i_rstn;
   logic             req;
   odac_op_t         op;
   logic [6:0]       addr;
   logic [7:0]       ca;
   logic [15:0]      wdata;
   logic [2:0]       strap;
   logic             busy, done, nack, upd;
   logic [15:0]      rdata;
   logic [95:0]      code;
   logic [11:0]      inr [8] = '{default: 12'h000};
   logic [11:0]      dac [8] = '{default: 12'h000};
   logic [7:0]       sh = 8'h00;
   logic [7:0]       first_b = 8'h00;
   int               nb = 0;
   int               mismatches = 0;
   int               n_tests = 0;
   localparam logic [6:0] dev_a = ODAC_BASE_ADDR + 7'h5;
   odac_if link_if ();
   odac_target odac_target_inst (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .link(link_if),
      .i_addr_strap(strap), .o_dac_code(code), .o_update(upd));
   odac_ctl odac_ctl_inst (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .link(link_if),
      .i_req(req), .i_op(op), .i_addr(addr), .i_ca(ca), .i_wdata(wdata),
      .o_busy(busy), .o_done(done), .o_nack(nack), .o_rdata(rdata));
   odac_link_checker odac_link_checker_inst (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
      .scl(link_if.scl), .sda_ctl_o(link_if.sda_ctl_o), .sda_ctl_oe(link_if.sda_ctl_oe),
      .sda_dev_o(link_if.sda_dev_o), .sda_dev_oe(link_if.sda_dev_oe), .sda(link_if.sda));
   initial begin
      i_ref_clk = 1'b0;
      forever #25 i_ref_clk = ~i_ref_clk;
   end
   // Keep the address byte of the latest start, as seen on the wire.
   always @(negedge link_if.sda) if (link_if.scl === 1'b1) nb = 0;
   always @(posedge link_if.scl) begin
      sh = {sh[6:0], link_if.sda};
      nb = nb + 1;
      if (nb == 8) first_b = sh;
   end
   task automatic check(input logic [95:0] seen, input logic [95:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("mismatches %0d of %0d comparisons", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   function automatic logic [95:0] pack();
      logic [95:0] e;
      for (int i = 0; i < ODAC_NCH; i++) e[i*12 +: 12] = dac[i];
      return e;
   endfunction
   // Requests stay up until busy is seen, so none is lost to an idle edge.
   task automatic do_op(input odac_op_t o, input logic [6:0] a, input logic [7:0] c,
                        input logic [15:0] d);
      int n;
      @(posedge i_ref_clk);
      #1;
      op = o;
      addr = a;
      ca = c;
      wdata = d;
      req = 1'b1;
      n = 0;
      while (busy !== 1'b1 && n < 50) begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end
      req = 1'b0;
      while (done !== 1'b1 && n < 3000) begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end
      if (n >= 3000) begin
         mismatches++;
         $display("unexpected at %0t: frame never completed", $time);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [3:0] c, input logic [3:0] ch,
                     input logic [15:0] d);
      logic ok;
      ok = (a == dev_a) || (a == ODAC_BCAST_ADDR);
      do_op(ODAC_OP_WRITE, a, {c, ch}, d);
      check(nack, !ok);
      for (int i = 0; i < ODAC_NCH; i++) begin
         if (ok && (ch == ODAC_CH_ALL || ch == 4'(i))) begin
            if (c != ODAC_CMD_UPD) inr[i] = d[15:4];
            if (c == ODAC_CMD_UPD || c == ODAC_CMD_WR_UPD) dac[i] = inr[i];
         end
         if (ok && c == ODAC_CMD_WR_ALL) dac[i] = inr[i];
      end
      check(code, pack());
   endtask
   task automatic rd(input odac_op_t o, input logic [6:0] a, input logic [7:0] c,
                     input logic [11:0] e, input logic bad);
      do_op(o, a, c, 16'h0000);
      check(nack, bad);
      if (!bad) check(rdata[15:4], e);
      if (!bad) check(first_b, {a, 1'b1});
   endtask
   initial begin
      i_rstn = 1'b0;
      req = 1'b0;
      op = ODAC_OP_WRITE;
      addr = 7'h00;
      ca = 8'h00;
      wdata = 16'h0000;
      strap = 3'h5;
      repeat (12) @(posedge i_ref_clk);
      #1 i_rstn = 1'b1;
      check(code, 96'h0);
      check({link_if.scl, link_if.sda}, 2'b11);
      wr(dev_a, ODAC_CMD_WR, 4'h2, 16'habc0);
      wr(dev_a, ODAC_CMD_UPD, 4'h2, 16'h0000);
      wr(dev_a, ODAC_CMD_WR_UPD, 4'h5, 16'h123f);
      wr(dev_a, ODAC_CMD_WR, 4'h1, 16'h5550);
      wr(dev_a, ODAC_CMD_WR_ALL, 4'h0, 16'h9990);
      wr(ODAC_BCAST_ADDR, ODAC_CMD_WR_UPD, ODAC_CH_ALL, 16'h7770);
      check(first_b, {ODAC_BCAST_ADDR, 1'b0});
      wr(dev_a + 7'h1, ODAC_CMD_WR_UPD, 4'h0, 16'h1110);
      wr(dev_a, ODAC_CMD_WR, 4'h3, 16'h9a50);
      rd(ODAC_OP_READ_LAST, dev_a, 8'h00, 12'h9a5, 1'b0);
      rd(ODAC_OP_READ, dev_a, {ODAC_CMD_WR, 4'h5}, 12'h777, 1'b0);
      rd(ODAC_OP_READ, ODAC_BCAST_ADDR, 8'h00, 12'h000, 1'b1);
      wrap_up;
   end
   // Eleven frames need about 3200 cycles; allow over six times that.
   initial begin
      repeat (20000) @(posedge i_ref_clk);
      mismatches++;
      $display("unexpected at %0t: watchdog expired", $time);
      wrap_up;
   end
endmodule // tb
